/* shared/deep_sleep_consts.vh */
// constants for the deep sleep entry and exit controller
`ifndef DEEP_SLEEP_CONSTS_VH
`define DEEP_SLEEP_CONSTS_VH
`define ADDR_CONTROL 12'h000
`define ADDR_WAKE 12'h004
`define ADDR_SCRATCH_A 12'h008
`define ADDR_SCRATCH_B 12'h00C
`define ADDR_TRACE 12'h010
`define ADDR_CONFIG4 12'h014
`define BIT_ARM 15
`define BIT_BROWNOUT 1
`define BIT_RELEASE 0
`define BIT_PENDING 15
`define BIT_CFG_BROWNOUT 6
`define WAKE_POR 0
`define WAKE_MASTER_CLEAR_PIN 1
`define WAKE_ALARM 2
`define WAKE_EXT 3
`define WAKE_WDOG 4
`define ARM_WINDOW_CYCLES 2'h3
`define RESET_SEQ_CYCLES 4'h8
`endif

/* rtl/arm_window.v */
// arming window counter for deep sleep entry
`timescale 1ns/1ps
module arm_window (
   input wire CLK_I,
   input wire RST_I,
   input wire start_i,
   input wire stop_i,
   input wire tick_i,
   output reg expire_o
);
`include "deep_sleep_consts.vh"
reg [1:0] count;
reg running;
always @(posedge CLK_I) begin
   if (RST_I) begin
      count <= 2'h0;
      running <= 1'b0;
      expire_o <= 1'b0;
   end else begin
      expire_o <= 1'b0;
      if (start_i) begin
         count <= 2'h0;
         running <= 1'b1;
      end else if (stop_i) begin
         running <= 1'b0;
      end else if (running && tick_i) begin
         if (count == `ARM_WINDOW_CYCLES - 2'h1) begin
            running <= 1'b0;
            expire_o <= 1'b1;
         end else begin
            count <= count + 2'h1;
         end
      end
   end
end
endmodule

/* rtl/deep_sleep_ctrl.v */
// deep sleep entry and exit controller with apb registers
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
module deep_sleep_ctrl (
   input wire CLK_I,
   input wire RST_I,
   input wire PSEL_I,
   input wire PENABLE_I,
   input wire PWRITE_I,
   input wire [11:0] PADDR_I,
   input wire [31:0] PWDATA_I,
   output wire PREADY_O,
   output wire PSLVERR_O,
   output reg [31:0] PRDATA_O,
   input wire INSTR_TICK_I,
   input wire PWRSAV_I,
   input wire IRQ_PENDING_I,
   input wire POR_EVENT_I,
   input wire MASTER_CLEAR_PIN_I,
   input wire CALENDAR_ALARM_I,
   input wire CALENDAR_ENABLE_I,
   input wire EXTERNAL_WAKE_PIN_I,
   input wire EXT_WAKE_ENABLE_I,
   input wire EXT_WAKE_POLARITY_I,
   input wire WATCHDOG_TIMEOUT_I,
   input wire BROWNOUT_EVENT_I,
   input wire REGULATOR_ENABLE_I,
   output wire DEEP_SLEEP_O,
   output wire CORE_SUPPLY_OFF_O,
   output wire CORE_RESET_O,
   output wire IRQ_DISCARD_O,
   output wire IO_FREEZE_O,
   output wire CALENDAR_RUN_O,
   output wire DEEP_WATCHDOG_RUN_O,
   output wire DEEP_BROWNOUT_RUN_O,
   output wire SKIPPED_O
);
`include "deep_sleep_consts.vh"
// ----------------------------------------
// states
// ----------------------------------------
localparam ST_RUN = 3'b001;
localparam ST_SLEEP = 3'b010;
localparam ST_WAKE = 3'b100;
reg [2:0] state;
reg arm;
reg release_hold;
reg brownout_flag;
reg [4:0] wake_flags;
reg [15:0] scratch_a;
reg [15:0] scratch_b;
reg [15:0] config4;
reg [3:0] seq_count;
reg ext_entry_level;
reg skipped;
// ----------------------------------------
// apb decode
// ----------------------------------------
wire wr = PSEL_I && PENABLE_I && PWRITE_I;
wire rd_any = PSEL_I && PENABLE_I;
wire rd_setup = PSEL_I && !PENABLE_I && !PWRITE_I;
// ----------------------------------------
// address selects
// ----------------------------------------
wire sel_control = PADDR_I == `ADDR_CONTROL;
wire sel_wake = PADDR_I == `ADDR_WAKE;
wire sel_scratch_a = PADDR_I == `ADDR_SCRATCH_A;
wire sel_scratch_b = PADDR_I == `ADDR_SCRATCH_B;
wire sel_trace = PADDR_I == `ADDR_TRACE;
wire sel_config4 = PADDR_I == `ADDR_CONFIG4;
function mapped;
   input [11:0] a;
   begin
      if (a == `ADDR_CONTROL) begin
         mapped = 1'b1;
      end else if (a == `ADDR_WAKE) begin
         mapped = 1'b1;
      end else if (a == `ADDR_SCRATCH_A) begin
         mapped = 1'b1;
      end else if (a == `ADDR_SCRATCH_B) begin
         mapped = 1'b1;
      end else if (a == `ADDR_TRACE) begin
         mapped = 1'b1;
      end else if (a == `ADDR_CONFIG4) begin
         mapped = 1'b1;
      end else begin
         mapped = 1'b0;
      end
   end
endfunction
assign PREADY_O = 1'b1;
assign PSLVERR_O = rd_any && !mapped(PADDR_I);
wire wr_ctrl = wr && sel_control;
wire wr_scratch_a = wr && sel_scratch_a;
wire wr_scratch_b = wr && sel_scratch_b;
wire wr_config4 = wr && sel_config4;
wire arm_set = wr_ctrl && PWDATA_I[`BIT_ARM] && !arm && state == ST_RUN;
wire expire;
// ----------------------------------------
// entry decision
// ----------------------------------------
wire ext_asserted = EXTERNAL_WAKE_PIN_I == EXT_WAKE_POLARITY_I;
wire enter = state == ST_RUN && arm && PWRSAV_I && !IRQ_PENDING_I
   && REGULATOR_ENABLE_I;
wire cfg_bor = config4[`BIT_CFG_BROWNOUT];
// ----------------------------------------
// wake source detection
// ----------------------------------------
wire ev_por = POR_EVENT_I;
wire ev_master_clear_pin = !MASTER_CLEAR_PIN_I;
wire ev_alarm = CALENDAR_ALARM_I && CALENDAR_ENABLE_I;
wire ev_ext = EXT_WAKE_ENABLE_I && ext_asserted && !ext_entry_level;
wire ev_wdog = WATCHDOG_TIMEOUT_I;
wire ev_bor = cfg_bor && BROWNOUT_EVENT_I;
wire [4:0] wake_vec = {ev_wdog, ev_ext, ev_alarm, ev_master_clear_pin, ev_por | ev_bor};
wire wake = state == ST_SLEEP && (|wake_vec);
arm_window u_window (
   .CLK_I(CLK_I),
   .RST_I(RST_I),
   .start_i(arm_set),
   .stop_i(enter || state != ST_RUN),
   .tick_i(INSTR_TICK_I),
   .expire_o(expire)
);
// ----------------------------------------
// control state
// ----------------------------------------
always @(posedge CLK_I) begin
   if (RST_I) begin
      state <= ST_RUN;
      arm <= 1'b0;
      release_hold <= 1'b0;
      brownout_flag <= 1'b0;
      wake_flags <= 5'h00;
      scratch_a <= 16'h0000;
      scratch_b <= 16'h0000;
      config4 <= 16'h0000;
      seq_count <= 4'h0;
      ext_entry_level <= 1'b0;
      skipped <= 1'b0;
   end else begin
      skipped <= state == ST_RUN && arm && PWRSAV_I && IRQ_PENDING_I;
      case (state)
         ST_RUN: begin
            if (arm_set) begin
               arm <= 1'b1;
               wake_flags <= 5'h00;
            end else if (expire && !enter) begin
               arm <= 1'b0;
            end else if (wr_ctrl && !PWDATA_I[`BIT_ARM]) begin
               arm <= 1'b0;
            end
            if (wr_ctrl && !PWDATA_I[`BIT_RELEASE]) begin
               release_hold <= 1'b0;
            end
            if (wr_ctrl && !PWDATA_I[`BIT_BROWNOUT]) begin
               brownout_flag <= 1'b0;
            end
            if (wr_scratch_a) begin
               scratch_a <= PWDATA_I[15:0];
            end
            if (wr_scratch_b) begin
               scratch_b <= PWDATA_I[15:0];
            end
            if (wr_config4) begin
               config4 <= PWDATA_I[15:0];
            end
            if (enter) begin
               state <= ST_SLEEP;
               release_hold <= 1'b1;
               ext_entry_level <= ext_asserted;
            end
         end
         ST_SLEEP: begin
            if (!ext_asserted) begin
               ext_entry_level <= 1'b0;
            end
            if (BROWNOUT_EVENT_I && cfg_bor) begin
               brownout_flag <= 1'b1;
            end
            if (wake) begin
               state <= ST_WAKE;
               arm <= 1'b0;
               wake_flags <= wake_vec;
               seq_count <= 4'h0;
               if (ev_por || ev_bor) begin
                  release_hold <= 1'b0;
                  scratch_a <= 16'h0000;
                  scratch_b <= 16'h0000;
               end
            end
         end
         ST_WAKE: begin
            // flags frozen while the reset sequence runs
            if (seq_count == `RESET_SEQ_CYCLES - 4'h1) begin
               state <= ST_RUN;
            end else begin
               seq_count <= seq_count + 4'h1;
            end
         end
         default: begin
            state <= ST_RUN;
         end
      endcase
   end
end
// ----------------------------------------
// read data
// ----------------------------------------
always @(posedge CLK_I) begin
   if (RST_I) begin
      PRDATA_O <= 32'h00000000;
   end else if (rd_setup) begin
      if (sel_control) begin
         PRDATA_O <= {16'h0000, arm, 13'h0000, brownout_flag, release_hold};
      end else if (sel_wake) begin
         PRDATA_O <= {27'h0, wake_flags};
      end else if (sel_scratch_a) begin
         PRDATA_O <= {16'h0000, scratch_a};
      end else if (sel_scratch_b) begin
         PRDATA_O <= {16'h0000, scratch_b};
      end else if (sel_trace) begin
         PRDATA_O <= {16'h0000, IRQ_PENDING_I, 15'h0000};
      end else if (sel_config4) begin
         PRDATA_O <= {16'h0000, config4};
      end else begin
         PRDATA_O <= 32'h00000000;
      end
   end
end
// ----------------------------------------
// outputs
// ----------------------------------------
assign DEEP_SLEEP_O = state == ST_SLEEP;
assign CORE_SUPPLY_OFF_O = state == ST_SLEEP;
assign CORE_RESET_O = state != ST_RUN;
assign IRQ_DISCARD_O = enter;
assign IO_FREEZE_O = release_hold;
assign CALENDAR_RUN_O = CALENDAR_ENABLE_I;
assign DEEP_WATCHDOG_RUN_O = state == ST_SLEEP;
assign DEEP_BROWNOUT_RUN_O = state == ST_SLEEP && cfg_bor;
assign SKIPPED_O = skipped;
endmodule

/* verif/deep_sleep_ctrl_chk.sv */
// port checker for the deep sleep controller
`timescale 1ns/1ps
module deep_sleep_ctrl_chk (
   input wire CLK_I,
   input wire RST_I,
   input wire PWRSAV_I,
   input wire IRQ_PENDING_I,
   input wire REGULATOR_ENABLE_I,
   input wire MASTER_CLEAR_PIN_I,
   input wire CALENDAR_ALARM_I,
   input wire CALENDAR_ENABLE_I,
   input wire WATCHDOG_TIMEOUT_I,
   input wire DEEP_SLEEP_O,
   input wire CORE_RESET_O,
   input wire IRQ_DISCARD_O,
   input wire SKIPPED_O
);
   default clocking @(posedge CLK_I); endclocking
   default disable iff (RST_I);
   entry_gate_a: assert property ($rose(DEEP_SLEEP_O) |-> $past(PWRSAV_I && !IRQ_PENDING_I))
      else $error("sleep entered without a clean power-save");
   regulator_gate_a: assert property ($rose(DEEP_SLEEP_O) |-> $past(REGULATOR_ENABLE_I))
      else $error("sleep entered with regulator off");
   discard_entry_a: assert property (IRQ_DISCARD_O |-> ##[0:1] DEEP_SLEEP_O)
      else $error("interrupt discard outside entry");
   master_clear_pin_wake_a: assert property (DEEP_SLEEP_O && !MASTER_CLEAR_PIN_I |=> !DEEP_SLEEP_O)
      else $error("master clear did not wake");
   alarm_wake_a: assert property (DEEP_SLEEP_O && CALENDAR_ALARM_I && CALENDAR_ENABLE_I |=> !DEEP_SLEEP_O)
      else $error("enabled alarm did not wake");
   wdog_wake_a: assert property (DEEP_SLEEP_O && WATCHDOG_TIMEOUT_I |=> !DEEP_SLEEP_O)
      else $error("watchdog timeout did not wake");
   wake_reset_a: assert property ($fell(DEEP_SLEEP_O) |-> CORE_RESET_O [*8] ##1 !CORE_RESET_O)
      else $error("wake reset sequence length wrong");
   skip_flag_a: assert property (SKIPPED_O |-> !DEEP_SLEEP_O && $past(PWRSAV_I && IRQ_PENDING_I))
      else $error("skip flag without pending power-save");
   cover property ($rose(DEEP_SLEEP_O));
   cover property ($fell(CORE_RESET_O));
   cover property (SKIPPED_O);
endmodule

/* verif/core_model.sv */
// processor core model giving instruction ticks and power-save
`timescale 1ns/1ps
module core_model (
   input wire clk_i,
   input wire rst_i,
   input wire go_i,
   input wire [1:0] gap_i,
   output reg tick_o,
   output reg pwrsav_o
);
   reg busy;
   reg [1:0] c;
   reg [1:0] n;
   always @(posedge clk_i) begin
      pwrsav_o <= 1'b0;
      if (rst_i) begin
         tick_o <= 1'b0;
         busy <= 1'b0;
         c <= 2'h0;
         n <= 2'h0;
      end else begin
         c <= c + 2'h1;
         tick_o <= (c == 2'h3);
         if (go_i) begin
            busy <= 1'b1;
            n <= 2'h0;
         end else if (busy && n == gap_i) begin
            pwrsav_o <= 1'b1;
            busy <= 1'b0;
         end else if (busy && tick_o) begin
            n <= n + 2'h1;
         end
      end
   end
endmodule

/* verif/tb_deep_sleep_ctrl.sv */
// self-checking bench for the deep sleep controller
`include "deep_sleep_consts.vh"
`timescale 1ns/1ps
module tb_deep_sleep_ctrl;
   reg clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, go = 1'b0;
   reg irq = 1'b0, cal = 1'b1, regen = 1'b1, gap = 1'b0;
   reg [11:0] padr = 12'h000;
   reg [31:0] pwd = 32'h00000000, q;
   reg e = 1'b0;
   wire sup, calr, wdr, bdr, err;
   reg [4:0] ev = 5'h00;
   integer miscompares = 0, check_count = 0, k, s;
   wire rdy, tick, sav, ds, crst, frz;
   wire [31:0] prd;
   always #5 clk = !clk;
   core_model i_core_model (.clk_i(clk), .rst_i(rst), .go_i(go), .gap_i({1'b0, gap}),
      .tick_o(tick), .pwrsav_o(sav));
   deep_sleep_ctrl i_deep_sleep_ctrl (.CLK_I(clk), .RST_I(rst), .PSEL_I(psel),
      .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd), .PREADY_O(rdy),
      .PSLVERR_O(err), .PRDATA_O(prd), .INSTR_TICK_I(tick), .PWRSAV_I(sav),
      .IRQ_PENDING_I(irq), .POR_EVENT_I(1'b0), .MASTER_CLEAR_PIN_I(!ev[1]),
      .CALENDAR_ALARM_I(ev[2]), .CALENDAR_ENABLE_I(cal), .EXTERNAL_WAKE_PIN_I(ev[3]),
      .EXT_WAKE_ENABLE_I(1'b1), .EXT_WAKE_POLARITY_I(1'b1), .WATCHDOG_TIMEOUT_I(ev[4]),
      .BROWNOUT_EVENT_I(1'b0), .REGULATOR_ENABLE_I(regen), .DEEP_SLEEP_O(ds),
      .CORE_SUPPLY_OFF_O(sup), .CORE_RESET_O(crst), .IRQ_DISCARD_O(), .IO_FREEZE_O(frz),
      .CALENDAR_RUN_O(calr), .DEEP_WATCHDOG_RUN_O(wdr), .DEEP_BROWNOUT_RUN_O(bdr),
      .SKIPPED_O());
   task chk(input [31:0] got, input [31:0] exp);
      begin
         check_count = check_count + 1;
         if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task complete_run;
      begin
         $display("checks %0d mismatches %0d", check_count, miscompares);
         if (miscompares == 0 && check_count > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   task limit(input integer lim);
      if (k >= lim) begin
         miscompares = miscompares + 1;
         complete_run;
      end
   endtask
   task apb(input w, input [11:0] a, input [31:0] d);
      begin
         @(posedge clk);
         psel <= 1'b1;
         pwr <= w;
         padr <= a;
         pwd <= d;
         @(posedge clk);
         pen <= 1'b1;
         k = 0;
         do begin
            @(posedge clk);
            k = k + 1;
         end while (rdy !== 1'b1 && k < 20);
         q = prd;
         e = err;
         psel <= 1'b0;
         pen <= 1'b0;
         limit(20);
      end
   endtask
   task wait_sig(input w, input v);
      begin
         k = 0;
         while (((w ? crst : ds) !== v) && k < 100) begin
            @(posedge clk);
            k = k + 1;
         end
         limit(100);
      end
   endtask
   task arm(input g);
      begin
         apb(1'b1, `ADDR_CONTROL, 32'h00000001 << `BIT_ARM);
         go <= g;
         @(posedge clk);
         go <= 1'b0;
      end
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      arm(1'b0);
      apb(1'b0, `ADDR_CONTROL, 32'h0);
      chk(q, 32'h00008000);
      apb(1'b0, 12'h018, 32'h0);
      chk({31'h0, e}, 32'h00000001);
      chk(q, 32'h00000000);
      repeat (16) @(posedge clk);
      apb(1'b0, `ADDR_CONTROL, 32'h0);
      chk(q, 32'h00000000);
      $display("test window done");
      apb(1'b1, `ADDR_SCRATCH_A, 32'h0000A5A5);
      apb(1'b1, `ADDR_CONFIG4, 32'h00000001 << `BIT_CFG_BROWNOUT);
      for (s = 1; s < 5; s = s + 1) begin
         gap <= s[0] | s[1];
         apb(1'b1, `ADDR_CONTROL, 32'h0);
         repeat (12) @(posedge clk);
         arm(1'b1);
         wait_sig(1'b0, 1'b1);
         chk({27'h0, sup, wdr, bdr, crst, calr}, 32'h0000001F);
         if (s == 2) begin
            cal <= 1'b0;
            ev <= 5'h04;
            repeat (4) @(posedge clk);
            chk({31'h0, ds}, 32'h00000001);
            cal <= 1'b1;
         end
         ev <= 5'h01 << s;
         wait_sig(1'b0, 1'b0);
         ev <= 5'h10;
         wait_sig(1'b1, 1'b0);
         ev <= 5'h00;
         apb(1'b0, `ADDR_WAKE, 32'h0);
         chk(q, 32'h00000001 << s);
         apb(1'b0, `ADDR_CONTROL, 32'h0);
         chk(q & 32'h00008000, 32'h0);
      end
      apb(1'b0, `ADDR_SCRATCH_A, 32'h0);
      chk(q, 32'h0000A5A5);
      chk({31'h0, frz}, 32'h00000001);
      apb(1'b1, `ADDR_CONTROL, 32'h0);
      @(posedge clk);
      chk({31'h0, frz}, 32'h0);
      $display("test wake done");
      for (s = 0; s < 2; s = s + 1) begin
         irq <= !s[0];
         regen <= !s[0];
         apb(1'b0, `ADDR_TRACE, 32'h0);
         chk(q, {16'h0000, !s[0], 15'h0000});
         arm(1'b1);
         repeat (12) @(posedge clk);
         chk({31'h0, ds}, 32'h0);
      end
      $display("test blocked entry done");
      complete_run;
   end
endmodule
bind deep_sleep_ctrl deep_sleep_ctrl_chk i_deep_sleep_ctrl_chk (.*);
